// [rtl/cms_consts.svh]
// Constants of the clock monitor enable and phase offset register bank.
// Assumes inclusion by bare name from any file that needs the map.
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define CMS_ADDR_MON_EN     8'h8b
`define CMS_ADDR_PH1        8'h8c
`define CMS_ADDR_PH2        8'h8d
`define CMS_ADDR_PH3        8'h8e
`define CMS_ADDR_PH4        8'h8f
`define CMS_ADDR_PH5        8'h90

// ----------------------------------------------------------------------
// Field positions of the monitor enable register
// ----------------------------------------------------------------------
`define CMS_LOS_LO_MSB      7
`define CMS_LOS_LO_LSB      4
`define CMS_FOS_MSB         3
`define CMS_FOS_LSB         0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CMS_RST_MON_EN      8'hff
`define CMS_RST_PH1         8'h00
`define CMS_RST_PH2         8'h01
`define CMS_RST_PH3         8'h00
`define CMS_RST_PH4         8'h00
`define CMS_RST_PH5         8'h00
`define CMS_RDATA_UNMAPPED  8'h00

// ----------------------------------------------------------------------
// Configuration value under which the fifth offset is applied
// ----------------------------------------------------------------------
`define CMS_CFG_APPLY_PH5   1'b0

`endif

// [rtl/cms_pkg.sv]
// Types shared by the clock monitor enable and phase offset registers.
// Assumes nothing of its surroundings.
package cms_pkg;

    // Two-bit loss-of-signal monitor selection per input
    typedef enum logic [1:0]
    {
        CMS_LOS_OFF      = 2'b00,
        CMS_LOS_RESERVED = 2'b01,
        CMS_LOS_SLOW     = 2'b10,
        CMS_LOS_NORMAL   = 2'b11
    } cms_los_mode_t;

    // One 8-bit two's-complement phase offset
    typedef logic signed [7:0] cms_offset_t;

endpackage

// [rtl/cms_regs.sv]
// Monitor enable and per-output phase offset register bank.
// Assumes a simple same-clock register port and monitors on the same clock.
//
// How it works
// R1: Each input's two-bit loss monitor code means 00 off, 01 reserved, 10 slow variant, 11 normal.
// R2: The low bits of the four loss codes sit in bits 7..4 here; the high bits arrive from elsewhere.
// R3: Bits 3..0 hold one frequency-offset monitor enable per input, 1 on and 0 off.
// R4: Five 8-bit read/write fields hold signed phase offsets in high-speed divider clocks.
// R5: The fifth output's offset is applied only while the clock configuration select is 0.
// R6: After reset the second offset holds one and the other four hold zero.
// R7: The reserved loss code acts as off, and no loss alarm passes for a disabled input.
`include "cms_consts.svh"

module cms_regs
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [3:0] input_signal_loss_monitor_sel_hi,
    input  wire logic       clock_configuration_select,
    input  wire logic [3:0] loss_alarm_raw,
    output logic      [3:0] normal_signal_loss_monitor_on,
    output logic      [3:0] slow_signal_loss_monitor_on,
    output logic      [3:0] freq_offset_monitor_on,
    output logic      [3:0] loss_alarm,
    output logic      [7:0] output1_phase_offset,
    output logic      [7:0] output2_phase_offset,
    output logic      [7:0] output3_phase_offset,
    output logic      [7:0] output4_phase_offset,
    output logic      [7:0] output5_phase_offset,
    output logic      [7:0] output5_phase_offset_applied
);

    // ------------------------------------------------------------------
    // Decoding of a loss monitor code
    // ------------------------------------------------------------------
    function automatic cms_pkg::cms_los_mode_t cms_decode(input logic hi, input logic lo);
        cms_pkg::cms_los_mode_t m;
        m = cms_pkg::cms_los_mode_t'({hi, lo});
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]      mon_en;
    logic [7:0]      next_mon_en;
    logic [4:0][7:0] phase;
    logic [4:0][7:0] next_phase;
    logic [7:0]      next_reg_rdata;
    logic [7:0]      ph5_applied;
    logic [7:0]      next_ph5_applied;

    // Write decode; unmapped writes are dropped
    always_comb
    begin
        next_mon_en = mon_en;
        next_phase  = phase;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `CMS_ADDR_MON_EN: next_mon_en   = reg_wdata;  // [R2] [R3]
                `CMS_ADDR_PH1:    next_phase[0] = reg_wdata;  // [R4]
                `CMS_ADDR_PH2:    next_phase[1] = reg_wdata;  // [R4]
                `CMS_ADDR_PH3:    next_phase[2] = reg_wdata;  // [R4]
                `CMS_ADDR_PH4:    next_phase[3] = reg_wdata;  // [R4]
                `CMS_ADDR_PH5:    next_phase[4] = reg_wdata;  // [R4]
                default:          next_mon_en   = mon_en;
            endcase
        end
    end

    // Read decode, answered one cycle after the strobe
    always_comb
    begin
        next_reg_rdata = reg_rdata;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `CMS_ADDR_MON_EN: next_reg_rdata = mon_en;
                `CMS_ADDR_PH1:    next_reg_rdata = phase[0];
                `CMS_ADDR_PH2:    next_reg_rdata = phase[1];
                `CMS_ADDR_PH3:    next_reg_rdata = phase[2];
                `CMS_ADDR_PH4:    next_reg_rdata = phase[3];
                `CMS_ADDR_PH5:    next_reg_rdata = phase[4];
                default:          next_reg_rdata = `CMS_RDATA_UNMAPPED;
            endcase
        end
    end

    // Fifth offset goes to the output path only in the matching configuration
    always_comb
    begin
        if (clock_configuration_select == `CMS_CFG_APPLY_PH5)  // [R5]
            next_ph5_applied = next_phase[4];
        else
            next_ph5_applied = 8'h00;
    end

    // Register stage of the bank
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mon_en      <= `CMS_RST_MON_EN;
            phase[0]    <= `CMS_RST_PH1;  // [R6]
            phase[1]    <= `CMS_RST_PH2;  // [R6]
            phase[2]    <= `CMS_RST_PH3;  // [R6]
            phase[3]    <= `CMS_RST_PH4;  // [R6]
            phase[4]    <= `CMS_RST_PH5;  // [R6]
            reg_rdata   <= `CMS_RDATA_UNMAPPED;
            ph5_applied <= 8'h00;
        end
        else
        begin
            mon_en      <= next_mon_en;
            phase       <= next_phase;
            reg_rdata   <= next_reg_rdata;
            ph5_applied <= next_ph5_applied;
        end
    end

    assign output1_phase_offset         = phase[0];
    assign output2_phase_offset         = phase[1];
    assign output3_phase_offset         = phase[2];
    assign output4_phase_offset         = phase[3];
    assign output5_phase_offset         = phase[4];
    assign output5_phase_offset_applied = ph5_applied;

    // ------------------------------------------------------------------
    // Per-input monitor steering
    // ------------------------------------------------------------------
    logic [3:0] norm_q;
    logic [3:0] slow_q;
    logic [3:0] fos_q;
    logic [3:0] alarm_q;
    logic [3:0] next_norm;
    logic [3:0] next_slow;
    logic [3:0] next_fos;
    logic [3:0] next_alarm;

    // Decode from the next register value so steering tracks a write at once
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_input
            always_comb
            begin
                cms_pkg::cms_los_mode_t mode;
                mode = cms_decode(input_signal_loss_monitor_sel_hi[gi],
                                  next_mon_en[`CMS_LOS_LO_LSB + gi]);  // [R1] [R2]
                // Reserved code falls through to off, never a half-armed monitor
                next_norm[gi]  = (mode == cms_pkg::CMS_LOS_NORMAL);  // [R1] [R7]
                next_slow[gi]  = (mode == cms_pkg::CMS_LOS_SLOW);    // [R1] [R7]
                next_fos[gi]   = next_mon_en[`CMS_FOS_LSB + gi];     // [R3]
                next_alarm[gi] = loss_alarm_raw[gi] & (next_norm[gi] | next_slow[gi]);  // [R7]
            end
        end
    endgenerate

    // Steering outputs come from flip-flops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            norm_q  <= 4'h0;
            slow_q  <= 4'h0;
            fos_q   <= 4'h0;
            alarm_q <= 4'h0;
        end
        else
        begin
            norm_q  <= next_norm;
            slow_q  <= next_slow;
            fos_q   <= next_fos;
            alarm_q <= next_alarm;
        end
    end

    assign normal_signal_loss_monitor_on = norm_q;
    assign slow_signal_loss_monitor_on   = slow_q;
    assign freq_offset_monitor_on        = fos_q;
    assign loss_alarm                    = alarm_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_read_ph2;
        reg_rd && !reg_wr && reg_addr == `CMS_ADDR_PH2;
    endsequence

    sequence s_write_mon;
        reg_wr && reg_addr == `CMS_ADDR_MON_EN;
    endsequence

    // Only cycles without a write, so the stored code is the one decoded
    los_decode_a: assert property (  // [R1]
        !$past(reg_wr) |-> slow_q == ($past(input_signal_loss_monitor_sel_hi) &
        ~$past(mon_en[`CMS_LOS_LO_MSB:`CMS_LOS_LO_LSB])))
        else $error("slow monitor decode wrong");

    los_lowbit_a: assert property (  // [R2]
        reg_wr && reg_addr == `CMS_ADDR_MON_EN |=> norm_q[0] ==
        ($past(input_signal_loss_monitor_sel_hi[0]) && $past(reg_wdata[4])))
        else $error("loss low bit not taken from bit 4");

    fos_enable_a: assert property (  // [R3]
        s_write_mon |=> fos_q == $past(reg_wdata[`CMS_FOS_MSB:`CMS_FOS_LSB]))
        else $error("frequency monitor enables wrong");

    offset_rw_a: assert property (  // [R4]
        reg_wr && reg_addr == `CMS_ADDR_PH2 ##1 s_read_ph2 |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("phase offset readback mismatch");

    ph5_gate_a: assert property (  // [R5]
        $past(clock_configuration_select) != `CMS_CFG_APPLY_PH5 |->
        output5_phase_offset_applied == 8'h00)
        else $error("fifth offset applied in wrong configuration");

    ph5_pass_a: assert property (  // [R5]
        $past(clock_configuration_select) == `CMS_CFG_APPLY_PH5 |->
        output5_phase_offset_applied == output5_phase_offset)
        else $error("fifth offset not applied");

    reset_val_a: assert property (  // [R6]
        $rose(nrst) |-> output2_phase_offset == `CMS_RST_PH2 &&
        output1_phase_offset == `CMS_RST_PH1)
        else $error("phase offset reset value wrong");

    alarm_mask_a: assert property (  // [R7]
        (loss_alarm & ~(norm_q | slow_q)) == 4'h0)
        else $error("loss alarm on disabled input");

endmodule

// [verif/cms_regs_bench.sv]
// Self-checking bench for the monitor enable and phase offset bank.
// Assumes the bank on one 20 MHz clock, inputs driven at the falling edge.
`include "cms_consts.svh"

module cms_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk;
    logic       nrst;
    logic       reg_wr;
    logic       reg_rd;
    logic       sel;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [3:0] hi;
    logic [3:0] raw;
    logic [3:0] norm_on;
    logic [3:0] slow_on;
    logic [3:0] fos_on;
    logic [3:0] alarm;
    logic [7:0] ph1;
    logic [7:0] ph2;
    logic [7:0] ph3;
    logic [7:0] ph4;
    logic [7:0] ph5;
    logic [7:0] ph5_app;
    int         err_count;
    int         checked;

    cms_regs uut
    (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_signal_loss_monitor_sel_hi(hi), .clock_configuration_select(sel),
        .loss_alarm_raw(raw), .normal_signal_loss_monitor_on(norm_on),
        .slow_signal_loss_monitor_on(slow_on), .freq_offset_monitor_on(fos_on),
        .loss_alarm(alarm), .output1_phase_offset(ph1), .output2_phase_offset(ph2),
        .output3_phase_offset(ph3), .output4_phase_offset(ph4),
        .output5_phase_offset(ph5), .output5_phase_offset_applied(ph5_app)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Clock, 50 ns period
    always #25 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Extra idle edge keeps the strobe from being set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
        @(negedge clk);
    endtask

    task automatic do_reset;
        hi = 4'h0;
        nrst = 1'b0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset;
        logic [7:0] rv [6];
        rv = '{`CMS_RST_MON_EN, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++)
            rd(`CMS_ADDR_MON_EN + 8'(i), rv[i]);
        chk(ph1, 8'h00);
        chk(ph2, 8'h01);
        chk(ph3 | ph4 | ph5, 8'h00);
        // High bits zero give code 01 on every input
        chk({norm_on, slow_on}, 8'h00);
        chk(8'(fos_on), 8'h0f);
        chk(8'(alarm), 8'h00);
        $display("test reset done");
    endtask

    task automatic test_offsets;
        logic [7:0] v [5];
        v = '{8'h80, 8'h7f, 8'hff, 8'h01, 8'h55};
        // Back-to-back writes, then back-to-back reads
        reg_wr = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            reg_addr = `CMS_ADDR_PH1 + 8'(i);
            reg_wdata = v[i];
            @(negedge clk);
        end
        reg_wr = 1'b0;
        chk(ph1, v[0]);
        chk(ph2, v[1]);
        chk(ph3, v[2]);
        chk(ph4, v[3]);
        chk(ph5, v[4]);
        reg_rd = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            reg_addr = `CMS_ADDR_PH1 + 8'(i);
            @(negedge clk);
            chk(reg_rdata, v[i]);
        end
        reg_rd = 1'b0;
        @(negedge clk);
        // Unmapped place must not alias onto a neighbour
        wr(8'h91, 8'h5a);
        rd(8'h91, `CMS_RDATA_UNMAPPED);
        rd(`CMS_ADDR_PH5, v[4]);
        // Read straight after a write must return the new value
        reg_addr = `CMS_ADDR_PH2;
        reg_wdata = 8'hc3;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(reg_rdata, 8'hc3);
        @(negedge clk);
        $display("test offsets done");
    endtask

    task automatic test_monitor;
        logic [3:0] t [2][5];
        // hi, lo, fos, normal, slow: every code on some input
        t = '{'{4'b1100, 4'b1010, 4'h6, 4'b1000, 4'b0100},
              '{4'b0011, 4'b0101, 4'h9, 4'b0001, 4'b0010}};
        for (int r = 0; r < 2; r++)
        begin
            hi = t[r][0];
            wr(`CMS_ADDR_MON_EN, {t[r][1], t[r][2]});
            chk(8'(norm_on), 8'(t[r][3]));
            chk(8'(slow_on), 8'(t[r][4]));
            chk(8'(fos_on), 8'(t[r][2]));
            @(negedge clk);
            chk(8'(alarm), 8'(t[r][3] | t[r][4]));
            // Raw alarms must pass through, not just the enables
            raw = 4'h5;
            @(negedge clk);
            chk(8'(alarm), 8'(4'h5 & (t[r][3] | t[r][4])));
            raw = 4'hf;
            rd(`CMS_ADDR_MON_EN, {t[r][1], t[r][2]});
        end
        $display("test monitor done");
    endtask

    task automatic test_apply;
        sel = 1'b0;
        wr(`CMS_ADDR_PH5, 8'h9c);
        chk(ph5_app, 8'h9c);
        sel = 1'b1;
        repeat (2) @(negedge clk);
        chk(ph5_app, 8'h00);
        wr(`CMS_ADDR_PH5, 8'h3e);
        chk(ph5, 8'h3e);
        chk(ph5_app, 8'h00);
        sel = 1'b0;
        repeat (2) @(negedge clk);
        chk(ph5_app, 8'h3e);
        $display("test apply done");
    endtask

    // ------------------------------------------------------------------
    // Sequence, verdict and watchdog
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Second reset in mid-run must restore the defaults
    initial
    begin
        clk = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sel = 1'b0;
        raw = 4'hf;
        err_count = 0;
        checked = 0;
        do_reset();
        test_reset();
        test_offsets();
        test_monitor();
        test_apply();
        do_reset();
        test_reset();
        print_verdict();
    end

    // About 106 cycles are needed; allow over five times that
    initial
    begin
        #(50 * 600);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
